// ---- banked_data_memory_addressing.sv ----
// Banked data memory: address forming, storage, bank pointer and special register port
`timescale 1ns/1ps
`include "data_space_defs.svh"

// Notes on behaviour
// RULE_01 - Data space uses twelve bit byte addresses
// RULE_02 - Sixteen banks of 256 bytes, upper banks may be absent
// RULE_03 - Unimplemented locations read back as zero
// RULE_04 - Fast window reaches low RAM, top registers
// RULE_05 - Banked address is pointer high, operand low
// RULE_06 - Pointer upper nibble reads zero, ignores writes
// RULE_07 - Bank load instruction sets pointer from literal
// RULE_08 - Absent banks ignore writes, read zero
// RULE_09 - Full move uses twelve bit addresses only
// RULE_10 - Other instructions give eight bit operand only
// RULE_11 - Write to F9h in bank Fh hits PC low
// RULE_12 - Software must select bank before access
// RULE_13 - Select bit picks window or bank addressing
module banked_data_memory_addressing #(
  parameter int IMPL_BANKS = `DS_NUM_BANKS  // Banks backed by storage
) (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      op_valid,
  output      logic                      op_ready,
  input  wire data_space_pkg::op_e       op_code,
  input  wire logic                      op_banked,
  input  wire logic [`DS_LOW_W-1:0]      op_addr_low,
  input  wire logic [`DS_ADDR_W-1:0]     op_src_addr,
  input  wire logic [`DS_ADDR_W-1:0]     op_dst_addr,
  input  wire logic [7:0]                op_wdata,
  output      logic                      rd_valid,
  output      logic [7:0]                rd_data,
  output      logic [`DS_BANK_W-1:0]     bank_select,
  output      logic                      sfr_rd,
  output      logic [6:0]                sfr_rd_addr,
  input  wire logic [7:0]                sfr_rdata,
  output      logic                      sfr_wr,
  output      logic [6:0]                sfr_wr_addr,
  output      logic [7:0]                sfr_wdata,
  output      logic                      pc_low_wr
);
  import data_space_pkg::*;

  // ====================================================
  // Parameter check at elaboration
  // Fewer banks model a part with absent storage; more cannot be addressed
  if (IMPL_BANKS < 1 || IMPL_BANKS > `DS_NUM_BANKS) begin : g_bad_banks
    $error("IMPL_BANKS must lie between 1 and 16");
  end

  localparam int MEM_BYTES = `DS_NUM_BANKS * `DS_BANK_BYTES;  // Full 4096 byte space

  // ====================================================
  // State
  // Storage is a flat array; absent banks are masked by decode, not by size
  logic [7:0]             mem [0:MEM_BYTES-1];  // Byte storage for the whole space
  logic [`DS_BANK_W-1:0]  bank_pointer_reg;     // Only the low nibble exists
  logic [`DS_BANK_W-1:0]  bank_pointer_next;
  seq_state_e             state_reg;
  seq_state_e             state_next;
  logic [`DS_ADDR_W-1:0]  move_dst_reg;         // Destination held for move write
  logic [7:0]             move_data_reg;        // Byte fetched by move
  logic                   rd_valid_reg;
  logic [7:0]             rd_data_reg;
  logic                   sfr_wr_reg;
  logic [6:0]             sfr_wr_addr_reg;
  logic [7:0]             sfr_wdata_reg;
  logic                   pc_low_wr_reg;

  // ====================================================
  // Operation decode
  // Only one op is taken per edge, and op_code is one-hot
  wire idle       = (state_reg == ST_IDLE);
  wire take       = op_valid && idle;
  wire is_read    = take && (op_code == OP_READ);
  wire is_write   = take && (op_code == OP_WRITE);
  wire is_load    = take && (op_code == OP_LOAD_BANK);
  wire is_move    = take && (op_code == OP_MOVE);

  // Window maps low half to bank 0, high half to the register bank
  wire [`DS_BANK_W-1:0] window_bank = (op_addr_low < `DS_ACCESS_SPLIT) ? 4'h0 : 4'hF;  // RULE_04

  // Operand address, either through window or pointer
  wire [`DS_ADDR_W-1:0] short_addr = op_banked ? {bank_pointer_reg, op_addr_low}  // RULE_05 RULE_13
                                               : {window_bank, op_addr_low};      // RULE_10

  // Move carries full addresses and never looks at the pointer
  // So a stale bank left by earlier code cannot leak into a move
  wire [`DS_ADDR_W-1:0] rd_addr = (op_code == OP_MOVE) ? op_src_addr : short_addr;  // RULE_09 RULE_01

  // ====================================================
  // Read target classification
  // The pointer sits inside the register page, so it is carved out first
  wire                  rd_is_bsr  = (rd_addr == `DS_BANK_PTR_ADDR);
  wire                  rd_is_sfr  = (rd_addr >= `DS_SFR_BASE) && !rd_is_bsr;
  wire [`DS_BANK_W-1:0] rd_bank    = rd_addr[`DS_ADDR_W-1:`DS_LOW_W];
  wire                  rd_is_impl = (32'(rd_bank) < IMPL_BANKS);

  // Read mux; absent storage answers zero
  wire [7:0] rd_value = rd_is_bsr  ? {4'h0, bank_pointer_reg} :  // RULE_06
                        rd_is_sfr  ? sfr_rdata :
                        rd_is_impl ? mem[rd_addr] :               // RULE_02
                                     `DS_BYTE_ZERO;               // RULE_03 RULE_08

  // ====================================================
  // Write path: direct write now, or move write one cycle later
  // A move write never meets a new op: ready is low in that cycle
  wire                  move_wr  = (state_reg == ST_MOVE_WR);
  wire                  wr_fire  = is_write || move_wr;
  wire [`DS_ADDR_W-1:0] wr_addr  = move_wr ? move_dst_reg : short_addr;
  wire [7:0]            wr_value = move_wr ? move_data_reg : op_wdata;
  wire                  wr_is_bsr  = (wr_addr == `DS_BANK_PTR_ADDR);
  wire                  wr_is_sfr  = (wr_addr >= `DS_SFR_BASE) && !wr_is_bsr;
  wire [`DS_BANK_W-1:0] wr_bank    = wr_addr[`DS_ADDR_W-1:`DS_LOW_W];
  wire                  wr_is_impl = (32'(wr_bank) < IMPL_BANKS);
  wire                  wr_mem     = wr_fire && !wr_is_bsr && !wr_is_sfr && wr_is_impl;  // RULE_08
  wire                  wr_sfr     = wr_fire && wr_is_sfr;
  wire                  wr_pcl     = wr_fire && (wr_addr == `DS_PC_LOW_ADDR);         // RULE_11

  // Core is held off only while a move finishes its write
  assign op_ready = idle;

  // Combinational read strobe toward external registers
  // Register logic must answer in the same cycle; there is no wait state
  assign sfr_rd      = (is_read || is_move) && rd_is_sfr;
  assign sfr_rd_addr = rd_addr[6:0];

  // ====================================================
  // Bank pointer next value
  // Load and pointer write cannot coincide, as loads are taken only when idle
  always_comb begin
    bank_pointer_next = bank_pointer_reg;
    if (is_load) begin
      bank_pointer_next = op_wdata[`DS_BANK_W-1:0];  // RULE_07 RULE_06
    end else if (wr_fire && wr_is_bsr) begin
      bank_pointer_next = wr_value[`DS_BANK_W-1:0];  // RULE_06
    end
  end

  // ====================================================
  // Sequencer next state
  // Move needs a second cycle because storage has a single write port
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (is_move) begin
          state_next = ST_MOVE_WR;
        end
      end
      ST_MOVE_WR: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ====================================================
  // Control registers
  // Strobes are pulses, rebuilt from decode on every edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bank_pointer_reg <= `DS_BANK_PTR_RST;
      state_reg        <= ST_IDLE;
      rd_valid_reg     <= 1'b0;
      sfr_wr_reg       <= 1'b0;
      pc_low_wr_reg    <= 1'b0;
    end else begin
      bank_pointer_reg <= bank_pointer_next;
      state_reg        <= state_next;
      rd_valid_reg     <= is_read;
      sfr_wr_reg       <= wr_sfr;
      pc_low_wr_reg    <= wr_pcl;
    end
  end

  // ====================================================
  // Data registers; cleared on reset so outputs start defined
  // Each is loaded only by its own strobe and holds otherwise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_reg     <= `DS_BYTE_ZERO;
      move_data_reg   <= `DS_BYTE_ZERO;
      move_dst_reg    <= '0;
      sfr_wr_addr_reg <= '0;
      sfr_wdata_reg   <= `DS_BYTE_ZERO;
    end else begin
      if (is_read) begin
        rd_data_reg <= rd_value;
      end
      if (is_move) begin
        move_data_reg <= rd_value;
        move_dst_reg  <= op_dst_addr;  // RULE_09
      end
      if (wr_sfr) begin
        sfr_wr_addr_reg <= wr_addr[6:0];
        sfr_wdata_reg   <= wr_value;
      end
    end
  end

  // ====================================================
  // Storage array; writes to absent banks are dropped
  // No reset on storage: like RAM, contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (wr_mem) begin
      mem[wr_addr] <= wr_value;  // RULE_02
    end
  end

  // ====================================================
  // Outputs
  // Strobes other than sfr_rd come from flops so the register logic sees clean one-cycle pulses
  assign rd_valid    = rd_valid_reg;
  assign rd_data     = rd_data_reg;
  assign bank_select = bank_pointer_reg;
  assign sfr_wr      = sfr_wr_reg;
  assign sfr_wr_addr = sfr_wr_addr_reg;
  assign sfr_wdata   = sfr_wdata_reg;
  assign pc_low_wr   = pc_low_wr_reg;

endmodule

// ---- data_space_defs.svh ----
// Constants for the banked data memory addressing block
`ifndef DATA_SPACE_DEFS_SVH
`define DATA_SPACE_DEFS_SVH

// ====================================================
// Address geometry
`define DS_ADDR_W        12
`define DS_BANK_W        4
`define DS_LOW_W         8
`define DS_NUM_BANKS     16
`define DS_BANK_BYTES    256

// ====================================================
// Fixed locations in the top bank
`define DS_SFR_BASE      12'hF80
`define DS_BANK_PTR_ADDR 12'hFE0
`define DS_PC_LOW_ADDR   12'hFF9
`define DS_ACCESS_SPLIT  8'h80

// ====================================================
// Reset values
`define DS_BANK_PTR_RST  4'h0
`define DS_BYTE_ZERO     8'h00

`endif

// ---- data_space_pkg.sv ----
// Types shared by the banked data memory addressing block
package data_space_pkg;

  // ====================================================
  // Operations issued by the core, one-hot
  typedef enum logic [3:0] {
    OP_READ      = 4'b0001,
    OP_WRITE     = 4'b0010,
    OP_LOAD_BANK = 4'b0100,
    OP_MOVE      = 4'b1000
  } op_e;

  // ====================================================
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_MOVE_WR = 2'b10
  } seq_state_e;

endpackage

// ---- ds_properties.sv ----
// Checker for the banked data memory addressing block
`timescale 1ns/1ps
module ds_properties
  import data_space_pkg::*;
(
  input wire logic ref_clk, srst, op_valid, op_ready, op_banked, rd_valid, sfr_rd, sfr_wr, pc_low_wr,
  input wire data_space_pkg::op_e op_code,
  input wire logic [7:0] op_addr_low, op_wdata, rd_data, sfr_rdata, sfr_wdata,
  input wire logic [11:0] op_src_addr, op_dst_addr,
  input wire logic [3:0] bank_select,
  input wire logic [6:0] sfr_rd_addr, sfr_wr_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ====
  // Decoded takes; FE0h is the pointer, not external
  wire       take    = op_valid && op_ready;
  wire       rd_go   = take && op_code == OP_READ;
  wire       reg_hit = op_addr_low[7] && op_addr_low != 8'hE0;
  wire [6:0] dst_low = op_dst_addr[6:0];
  sequence move_take; take && op_code == OP_MOVE; endsequence
  sequence move_gap; !op_ready ##1 op_ready; endsequence
  sequence move_to_reg; move_take ##0 (op_dst_addr[11:7] == 5'h1F && op_dst_addr != 12'hFE0); endsequence
  chk_read_pulse: assert property (rd_go |=> rd_valid) else $error("read pulse missing");
  chk_read_cause: assert property (rd_valid |-> $past(rd_go)) else $error("stray read pulse");
  chk_move_gap: assert property (move_take |=> move_gap) else $error("move gap wrong");
  chk_move_reg_wr: assert property (move_to_reg |-> ##2 sfr_wr && sfr_wr_addr == $past(dst_low, 2))
    else $error("move target write wrong");
  chk_bank_load: assert property (
      take && op_code == OP_LOAD_BANK |=> bank_select == $past(op_wdata[3:0]))
    else $error("bank load wrong");
  chk_bank_hold: assert property (!op_valid && op_ready |=> $stable(bank_select)) else $error("bank drift");
  chk_window_reg: assert property (
      rd_go && !op_banked && reg_hit |-> sfr_rd && sfr_rd_addr == op_addr_low[6:0])
    else $error("window register read wrong");
  chk_window_ram: assert property (rd_go && !op_banked && !op_addr_low[7] |-> !sfr_rd)
    else $error("window low half left RAM");
  chk_pc_low: assert property (pc_low_wr |-> sfr_wr && sfr_wr_addr == 7'h79) else $error("pc low strobe wrong");
  chk_banked_wr: assert property (
      take && op_code == OP_WRITE && op_banked && bank_select == 4'hF && reg_hit
      |=> sfr_wr && sfr_wdata == $past(op_wdata)) else $error("banked register write wrong");
endmodule
bind banked_data_memory_addressing ds_properties chk_i (.*);

// ---- sfr_model.sv ----
// Stand-in for the special register logic on the core clock
`timescale 1ns/1ps
module sfr_model (
  input  wire logic       ref_clk,
  input  wire logic       sfr_rd,
  input  wire logic [6:0] sfr_rd_addr,
  output      logic [7:0] sfr_rdata
);
  logic [7:0] spin_reg = 8'h00;  // Changes every cycle, so stale data never looks valid
  // ====
  // Idle pattern counter
  always_ff @(posedge ref_clk) begin
    spin_reg <= spin_reg + 8'h01;
  end
  // Same-cycle answer: address with top bit set
  assign sfr_rdata = sfr_rd ? {1'b1, sfr_rd_addr} : spin_reg;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the banked data memory addressing block
`timescale 1ns/1ps
module tb_top;
  import data_space_pkg::*;
  logic ref_clk = 0, srst = 1, op_valid = 0, op_banked = 0;
  op_e op_code = OP_READ;
  logic [7:0] op_addr_low = 8'h00, op_wdata = 8'h00;
  logic [11:0] op_src_addr = 12'h000, op_dst_addr = 12'h000;
  wire logic op_ready, rd_valid, sfr_rd, sfr_wr, pc_low_wr;
  wire logic [7:0] rd_data, sfr_rdata, sfr_wdata;
  wire logic [3:0] bank_select;
  wire logic [6:0] sfr_rd_addr, sfr_wr_addr;
  int fails = 0, n_tests = 0;
  // ====
  // Clock and units; three banks so absent banks can be hit
  always #4 ref_clk = ~ref_clk;
  banked_data_memory_addressing #(.IMPL_BANKS(3)) DUT (.*);
  sfr_model partner (.ref_clk, .sfr_rd, .sfr_rd_addr, .sfr_rdata);
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One operation; returns at the falling edge after the take edge
  task automatic op(op_e c, logic b, logic [7:0] lo, logic [7:0] wd = 8'h00, logic [11:0] s = 12'h000,
                    logic [11:0] d = 12'h000);
    int n;
    @(negedge ref_clk);
    op_code = c;
    op_banked = b;
    op_addr_low = lo;
    op_wdata = wd;
    op_src_addr = s;
    op_dst_addr = d;
    op_valid = 1;
    for (n = 0; n < 4 && op_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 4) begin
      fails++;
      print_verdict();
    end
    @(negedge ref_clk);
    op_valid = 0;
  endtask
  task automatic rd(logic b, logic [7:0] lo, logic [7:0] exp);
    op(OP_READ, b, lo);
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask
  // ====
  // Scenarios
  task automatic t_bank_load();
    chk({4'h0, bank_select}, 8'h00);
    for (int k = 0; k < 16; k++) begin
      op(OP_LOAD_BANK, 1'b0, 8'h00, 8'hF0 | k[7:0]);
      chk({4'h0, bank_select}, k[7:0]);
      rd(1'b0, 8'hE0, k[7:0]);
    end
  endtask
  task automatic t_banks();
    for (int k = 0; k < 3; k++) begin
      op(OP_LOAD_BANK, 1'b0, 8'h00, k[7:0]);
      op(OP_WRITE, 1'b1, 8'h05, 8'hA0 + k[7:0]);
    end
    op(OP_LOAD_BANK, 1'b0, 8'h00, 8'h05);
    op(OP_WRITE, 1'b1, 8'h05, 8'h77);
    rd(1'b1, 8'h05, 8'h00);
    rd(1'b1, 8'h99, 8'h00);
    for (int k = 0; k < 3; k++) begin
      op(OP_LOAD_BANK, 1'b0, 8'h00, k[7:0]);
      rd(1'b1, 8'h05, 8'hA0 + k[7:0]);
    end
  endtask
  task automatic t_window();
    op(OP_WRITE, 1'b0, 8'h05, 8'h5C);
    rd(1'b1, 8'h05, 8'hA2);
    rd(1'b0, 8'h05, 8'h5C);
    rd(1'b0, 8'h85, 8'h85);
    op(OP_WRITE, 1'b0, 8'hE0, 8'hAF);
    chk({4'h0, bank_select}, 8'h0F);
    op(OP_WRITE, 1'b1, 8'hF9, 8'h42);
    chk({7'h0, pc_low_wr}, 8'h01);
    chk({1'b0, sfr_wr_addr}, 8'h79);
  endtask
  task automatic t_move();
    op(OP_MOVE, 1'b0, 8'h00, 8'h00, 12'h105, 12'h007);
    op(OP_MOVE, 1'b0, 8'h00, 8'h00, 12'h005, 12'hF8A);
    @(negedge ref_clk);
    chk({7'h0, sfr_wr}, 8'h01);
    chk(sfr_wdata, 8'h5C);
    chk({1'b0, sfr_wr_addr}, 8'h0A);
    chk({7'h0, pc_low_wr}, 8'h00);
    op(OP_LOAD_BANK, 1'b0, 8'h00, 8'h00);
    rd(1'b1, 8'h07, 8'hA1);
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    srst = 0;
    t_bank_load();
    t_banks();
    t_window();
    t_move();
    print_verdict();
  end
endmodule
